// file: hw/pps_power_path.sv
// Power-path selector, protection flags and AXI4-Lite register slave

// Register map, byte addresses:
//   0x48 control: bit 0 charge enable, bit 4 learn cycle, bits 11:9 depletion threshold
//   0x4C status: bits 10:6 live flags; writes answer OKAY and change nothing
//   0x50 events: same layout; a rising flag sets its bit, a written one clears it
//   0x54 event mask: same layout; irq is high while an unmasked event bit is set
//   Any other address answers SLVERR and reads as zero
// Write strobes are honoured per byte on every writable register.
// Flags from bit 6 up: battery on, adapter on, thermal shutdown, cold, hot.
// Comparator inputs are sampled on every edge; switch outputs follow one edge later
// and the status word one edge after that. Only adapter overcurrent acts within a cycle.
// After reset the control word, flags, events and mask are clear and both switches off.
// The depletion latch holds until learn cycle is cleared or the adapter goes away.
module pps_power_path (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Comparator results from the analog front end
  input wire logic adapter_detect_input,
  input wire logic system_rail_above_battery,
  input wire logic battery_below_depletion,
  input wire logic adapter_overcurrent,
  input wire logic die_temp_above_set,
  input wire logic die_temp_below_clear,
  input wire logic thermistor_sense_above_cold,
  input wire logic thermistor_sense_below_hot_start,
  input wire logic thermistor_sense_below_hot_run,
  // Switch selectors and analog controls
  output logic battery_switch_drive,
  output logic adapter_switch_drive,
  output logic five_volt_reference,
  output logic charger_enable,
  output logic hot_threshold_run_sel,
  output logic [2:0] battery_depletion_threshold,
  output logic alarm,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Software control word
  logic [31:0] ctrl_q;

  // Event bits, their next value, the event mask and the registered flags
  logic [pps_pkg::ST_NUM-1:0] irq_stat_q;
  logic [pps_pkg::ST_NUM-1:0] irq_stat_d;
  logic [pps_pkg::ST_NUM-1:0] irq_mask_q;
  logic [pps_pkg::ST_NUM-1:0] flags_q;

  // Power-path state
  logic bat_on_q;
  logic adp_on_q;
  logic depleted_q;

  // Protection state
  logic tsd_q;
  logic chg_q;
  logic vref_q;
  logic cold_q;
  logic hot_q;

  wire learn = ctrl_q[pps_pkg::CTRL_LEARN_BIT];
  wire chg_en_sw = ctrl_q[pps_pkg::CTRL_CHG_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Power-path selection

  // Once learn-cycle battery is depleted, stay on adapter until learn or adapter ends
  wire depleted_d = adapter_detect_input & learn & (depleted_q | battery_below_depletion);

  // Battery feeds the system with no adapter, or with one while learn cycle asks for it
  wire bat_want = ~adapter_detect_input | (learn & ~depleted_d);
  // A system rail above the battery would discharge into it, so the switch waits
  wire bat_on_d = bat_want & ~system_rail_above_battery;

  // Adapter feeds the system when present outside learn, or once learn has depleted
  // the battery; the two selectors are never on together
  wire adp_on_d = adapter_detect_input & (~learn | depleted_d) & ~adapter_overcurrent;

  // Switch states are registered so the selectors change on a clock edge; only overcurrent opens one between edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depleted_q <= 1'b0;
      bat_on_q <= 1'b0;
      adp_on_q <= 1'b0;
    end else begin
      depleted_q <= depleted_d;
      bat_on_q <= bat_on_d;
      adp_on_q <= adp_on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector outputs

  assign battery_switch_drive = bat_on_q;
  // Overcurrent gates the output directly so the switch opens without a cycle of delay
  assign adapter_switch_drive = adp_on_q & ~adapter_overcurrent;
  assign battery_depletion_threshold = ctrl_q[pps_pkg::CTRL_DEP_LSB +: pps_pkg::CTRL_DEP_W];

  ////////////////////////////////////////////////////////////////////////////
  // Thermal and thermistor protection

  // Hysteresis: set above the high trip, cleared only below the low trip
  wire tsd_d = die_temp_above_set | (tsd_q & ~die_temp_below_clear);

  // Start threshold while idle, run threshold while charging
  wire hot_raw = chg_q ? thermistor_sense_below_hot_run : thermistor_sense_below_hot_start;

  // Thermistor comparisons only mean something while the reference is up
  wire cold_d = adapter_detect_input & thermistor_sense_above_cold;
  wire hot_d = adapter_detect_input & hot_raw;

  // Charging needs software enable, an adapter and no thermal or thermistor inhibit
  wire chg_d = chg_en_sw & adapter_detect_input & ~tsd_d & ~cold_d & ~hot_d;

  // Protection states update every edge; cold and hot follow the reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsd_q <= 1'b0;
      chg_q <= 1'b0;
      vref_q <= 1'b0;
      cold_q <= 1'b0;
      hot_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
      chg_q <= chg_d;
      vref_q <= adapter_detect_input;
      cold_q <= cold_d;
      hot_q <= hot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection outputs

  // The reference comes up one edge after the adapter is seen
  assign five_volt_reference = vref_q;
  assign charger_enable = chg_q;
  assign hot_threshold_run_sel = chg_q;
  assign alarm = tsd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Live status flags and sticky event bits

  // Flags follow their causes every cycle with no latching
  wire [pps_pkg::ST_NUM-1:0] flags_now = {hot_q, cold_q, tsd_q, adp_on_q, bat_on_q};
  // Flags placed at their bit positions in the status word
  wire [31:0] status_word = 32'(flags_q) << pps_pkg::ST_LSB;

  // One register stage so a read never sees a flag mid-change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= pps_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // A half is refused while it is parked or while a response waits for the host
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;

  // A parked half stands in for the live one, so either order of arrival works
  wire aw_have = aw_held_q | aw_fire;
  wire w_have = w_held_q | w_fire;
  wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = aw_have & w_have;

  // Byte enables widened to a bit mask
  logic [31:0] wr_bmask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_bmask
      assign wr_bmask[gb*8 +: 8] = {8{wr_strb[gb]}};
    end
  endgenerate

  // Address decode; the status register is known but read only
  wire wr_ctrl = wr_go & (wr_addr == pps_pkg::CTRL_ADDR);
  wire wr_istat = wr_go & (wr_addr == pps_pkg::IRQ_STAT_ADDR);
  wire wr_imask = wr_go & (wr_addr == pps_pkg::IRQ_MASK_ADDR);
  wire wr_known = wr_ctrl | wr_istat | wr_imask | (wr_addr == pps_pkg::STAT_ADDR);

  // Only defined control bits change, each under its byte strobe
  wire [31:0] ctrl_bits = wr_bmask & pps_pkg::CTRL_WMASK;
  wire [31:0] ctrl_d = (ctrl_q & ~ctrl_bits) | (wr_data & ctrl_bits);

  // Event and mask writes use the flag field of the strobed data
  wire [31:0] wr_eff = wr_data & wr_bmask;
  wire [pps_pkg::ST_NUM-1:0] wr_field = wr_eff[pps_pkg::ST_LSB +: pps_pkg::ST_NUM];
  wire [pps_pkg::ST_NUM-1:0] mask_keep = ~(wr_bmask[pps_pkg::ST_LSB +: pps_pkg::ST_NUM]);

  // Park a half that arrives before its partner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_held_q <= aw_have & ~wr_go;
      w_held_q <= w_have & ~wr_go;
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write response

  // The response stands until the host takes it with bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= pps_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control and event mask registers

  // Nothing here waits on temperature, so the bus stays live during thermal shutdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= pps_pkg::CTRL_RESET;
      irq_mask_q <= pps_pkg::FLAGS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_d;
      end
      if (wr_imask) begin
        irq_mask_q <= (irq_mask_q & mask_keep) | wr_field;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: each flag rising sets its sticky bit, set beats clear

  wire [pps_pkg::ST_NUM-1:0] rise = flags_now & ~flags_q;
  wire [pps_pkg::ST_NUM-1:0] clr = wr_istat ? wr_field : '0;

  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::ST_NUM; gi++) begin : g_irq
      assign irq_stat_d[gi] = rise[gi] | (irq_stat_q[gi] & ~clr[gi]);
    end
  endgenerate

  // Event bits collect rises until a written one clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= pps_pkg::FLAGS_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level output while any unmasked event bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // One read at a time: a new address waits while read data stands
  assign s_axi_arready = ~rvalid_q;
  wire ar_fire = s_axi_arvalid & s_axi_arready;

  // Read decode on the address while it is offered
  wire rd_ctrl = s_axi_araddr == pps_pkg::CTRL_ADDR;
  wire rd_stat = s_axi_araddr == pps_pkg::STAT_ADDR;
  wire rd_istat = s_axi_araddr == pps_pkg::IRQ_STAT_ADDR;
  wire rd_imask = s_axi_araddr == pps_pkg::IRQ_MASK_ADDR;
  wire rd_known = rd_ctrl | rd_stat | rd_istat | rd_imask;
  wire [31:0] rd_word = rd_ctrl ? ctrl_q :
                        rd_stat ? status_word :
                        rd_istat ? (32'(irq_stat_q) << pps_pkg::ST_LSB) :
                        rd_imask ? (32'(irq_mask_q) << pps_pkg::ST_LSB) :
                        32'h0000_0000;

  // Data and response are captured with the address and stand until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pps_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_known ? pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // pps_power_path

// file: hw/pps_pkg.sv
// Package with register map, field positions and reset values of the power-path block
package pps_pkg;
  // Printed control register index; byte address is four times the index
  localparam logic [7:0] CTRL_INDEX = 8'h12;
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_INDEX * 4);
  localparam logic [7:0] STAT_ADDR = 8'h4C;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h50;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h54;
  // Control fields
  localparam int CTRL_CHG_EN_BIT = 0;
  localparam int CTRL_LEARN_BIT = 4;
  localparam int CTRL_DEP_LSB = 9;
  localparam int CTRL_DEP_W = 3;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0E11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status flag positions
  localparam int ST_BAT_BIT = 6;
  localparam int ST_ADP_BIT = 7;
  localparam int ST_TSD_BIT = 8;
  localparam int ST_COLD_BIT = 9;
  localparam int ST_HOT_BIT = 10;
  localparam int ST_LSB = 6;
  localparam int ST_NUM = 5;
  localparam logic [ST_NUM-1:0] FLAGS_RESET = 5'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Analog thresholds, documentation values for reference
  localparam int SYS_MARGIN_MV = 150;
  localparam int TSD_SET_DEGC = 145;
  localparam int TSD_CLR_DEGC = 130;
endpackage : pps_pkg

// file: sim/pps_power_path_properties.sv
// Concurrent checks on the selector, protection and reference outputs
module pps_power_path_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator inputs
  input wire logic adapter_detect_input,
  input wire logic system_rail_above_battery,
  input wire logic adapter_overcurrent,
  input wire logic die_temp_above_set,
  input wire logic die_temp_below_clear,
  // Selector and protection outputs
  input wire logic battery_switch_drive,
  input wire logic adapter_switch_drive,
  input wire logic five_volt_reference,
  input wire logic charger_enable,
  input wire logic hot_threshold_run_sel,
  input wire logic alarm
);
  logic up_q;
  // Keeps the first edge after reset release out of the antecedents
  always_ff @(posedge aclk) up_q <= aresetn;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_no_adapter;
    up_q && !adapter_detect_input && !system_rail_above_battery;
  endsequence
  sequence s_two_alarm;
    alarm [*2];
  endsequence
  property p_ovc_kill;
    adapter_overcurrent |-> !adapter_switch_drive;
  endproperty
  property p_bat_alone;
    s_no_adapter |=> battery_switch_drive;
  endproperty
  property p_sys_margin;
    up_q && system_rail_above_battery |=> !battery_switch_drive;
  endproperty
  property p_adp_absent;
    up_q && !adapter_detect_input |=> !adapter_switch_drive;
  endproperty
  property p_vref;
    up_q |=> five_volt_reference == $past(adapter_detect_input);
  endproperty
  property p_hot_sel;
    hot_threshold_run_sel == charger_enable;
  endproperty
  property p_tsd_set;
    up_q && die_temp_above_set |=> alarm;
  endproperty
  property p_tsd_hold;
    up_q && alarm && !die_temp_below_clear |=> alarm;
  endproperty
  property p_tsd_off;
    s_two_alarm |-> !charger_enable;
  endproperty
  property p_one_side;
    !(battery_switch_drive && adapter_switch_drive);
  endproperty
  property p_chg_ref;
    charger_enable |-> five_volt_reference;
  endproperty
  a_ovc_kill: assert property (p_ovc_kill) else $error("adapter on during overcurrent");
  a_bat_alone: assert property (p_bat_alone) else $error("battery off without adapter");
  a_sys_margin: assert property (p_sys_margin) else $error("battery on above margin");
  a_adp_absent: assert property (p_adp_absent) else $error("adapter on while absent");
  a_vref: assert property (p_vref) else $error("reference not following detect");
  a_hot_sel: assert property (p_hot_sel) else $error("hot threshold select wrong");
  a_tsd_set: assert property (p_tsd_set) else $error("no shutdown when hot");
  a_tsd_hold: assert property (p_tsd_hold) else $error("shutdown left early");
  a_tsd_off: assert property (p_tsd_off) else $error("charging in shutdown");
  a_one_side: assert property (p_one_side) else $error("both selectors on");
  a_chg_ref: assert property (p_chg_ref) else $error("charging without reference");
endmodule // pps_power_path_properties

bind pps_power_path pps_power_path_properties u_props (.aclk, .aresetn, .adapter_detect_input,
  .system_rail_above_battery, .adapter_overcurrent, .die_temp_above_set, .die_temp_below_clear,
  .battery_switch_drive, .adapter_switch_drive, .five_volt_reference, .charger_enable,
  .hot_threshold_run_sel, .alarm);

// file: sim/pps_axi_host.sv
// Register bus host model issuing single AXI4-Lite accesses
module pps_axi_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end
  // Released addresses and write data are inverted so stale values are never mistaken for live ones; strobes keep their value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule // pps_axi_host

// file: sim/pps_power_path_test.sv
// Self-checking bench for the power-path selector and its status flags
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pps_power_path_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [8:0] cmp = 9'h000;
  logic [31:0] d, r, s_axi_wdata, s_axi_rdata;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rs, s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic bat, ac, vref, chg, sel, alarm, irq, learn, latch, sd, en, hot, cold;
  logic [2:0] dep;
  int n_fail = 0;
  int tests_run = 0;
  always #4 aclk = ~aclk;
  pps_axi_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  pps_power_path dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .adapter_detect_input(cmp[0]),
    .system_rail_above_battery(cmp[1]), .battery_below_depletion(cmp[2]),
    .adapter_overcurrent(cmp[3]), .die_temp_above_set(cmp[4]), .die_temp_below_clear(cmp[5]),
    .thermistor_sense_above_cold(cmp[6]), .thermistor_sense_below_hot_start(cmp[7]),
    .thermistor_sense_below_hot_run(cmp[8]), .battery_switch_drive(bat),
    .adapter_switch_drive(ac), .five_volt_reference(vref), .charger_enable(chg),
    .hot_threshold_run_sel(sel), .battery_depletion_threshold(dep), .alarm(alarm), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Applies one comparator vector, updates the model and checks flags and pins
  task automatic step(input logic [8:0] v);
    cmp <= v;
    if (!v[0] || !learn) latch = 1'b0;
    else if (v[2]) latch = 1'b1;
    if (v[4]) sd = 1'b1;
    else if (v[5]) sd = 1'b0;
    cold = v[0] & v[6];
    repeat (3) begin
      hot = v[0] & (en ? v[8] : v[7]);
      en = v[0] & !sd & !cold & !hot;
    end
    repeat (4) @(posedge aclk);
    host.rd(pps_pkg::STAT_ADDR, d, rs);
    `CHK("status", {hot, cold, sd, v[0] & !v[3] & (!learn | latch),
      !v[1] & (!v[0] | learn & !latch)}, d[10:6])
    `CHK("pins", {!v[1] & (!v[0] | learn & !latch), v[0] & !v[3] & (!learn | latch), en, en,
      v[0], sd}, {bat, ac, chg, sel, vref, alarm})
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    results;
  end
  initial begin
    {r, learn, latch, sd, en} = {32'h431AB081, 4'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(pps_pkg::CTRL_ADDR, d, rs);
    `CHK("ctrl reset", pps_pkg::CTRL_RESET, d)
    host.wr(pps_pkg::CTRL_ADDR, 32'hFFFF_FFFF, 4'h1, rs);
    host.rd(pps_pkg::CTRL_ADDR, d, rs);
    `CHK("ctrl byte", 32'h0000_0011, d)
    host.wr(pps_pkg::CTRL_ADDR, 32'hFFFF_FFFF, 4'hF, rs);
    host.rd(pps_pkg::CTRL_ADDR, d, rs);
    `CHK("ctrl", 32'h0000_0E11, d)
    `CHK("depletion", 3'h7, dep)
    learn = 1'b1;
    host.wr(pps_pkg::STAT_ADDR, 32'hFFFF_FFFF, 4'hF, rs);
    `CHK("ro resp", pps_pkg::RESP_OKAY, rs)
    host.rd(8'h7C, d, rs);
    `CHK("unmapped", {pps_pkg::RESP_SLVERR, 32'h0}, {rs, d})
    for (int i = 0; i < 24; i++) begin
      r = lfsr(r);
      if (i % 4 == 0) begin
        host.wr(pps_pkg::CTRL_ADDR, {27'h0, r[20], 4'h1}, 4'hF, rs);
        learn = r[20];
        step(cmp);
      end
      step({r[8] & r[7], r[7:6], r[5] & !r[4], r[4:0]});
    end
    step(9'h021);
    `CHK("depletion off", 3'h0, dep)
    host.wr(pps_pkg::IRQ_MASK_ADDR, 32'h0, 4'hF, rs);
    host.wr(pps_pkg::IRQ_STAT_ADDR, 32'h0000_07C0, 4'hF, rs);
    step(9'h011);
    `CHK("irq masked", 1'b0, irq)
    host.rd(pps_pkg::IRQ_STAT_ADDR, d, rs);
    `CHK("sticky", 32'h0000_0100, d)
    host.wr(pps_pkg::IRQ_MASK_ADDR, 32'h0000_0100, 4'hF, rs);
    repeat (2) @(posedge aclk);
    `CHK("irq set", 1'b1, irq)
    host.wr(pps_pkg::IRQ_STAT_ADDR, 32'h0000_0100, 4'hF, rs);
    repeat (2) @(posedge aclk);
    `CHK("irq clear", 1'b0, irq)
    step(9'h021);
    results;
  end
endmodule // pps_power_path_test
